// file: src/ascp_pkg.sv
// ==========================================================================
// Shared constants of the serial configuration port
package ascp_pkg;
  // Frame layout: address first, then data
  localparam int ADDR_W = 10;
  localparam int DATA_W = 20;
  localparam int FRAME_W = ADDR_W + DATA_W;
  // Bit counts at the width of the frame bit counter
  localparam int CNT_W = 5;
  localparam logic [CNT_W-1:0] ADDR_CNT = CNT_W'(ADDR_W);
  localparam logic [CNT_W-1:0] FRAME_CNT = CNT_W'(FRAME_W);
  localparam logic [CNT_W-1:0] CNT_MAX = 5'h1F;
  // Control register address and its fields
  localparam logic [ADDR_W-1:0] CTRL_ADDR = 10'h000;
  localparam int RW_SEL_BIT = 0;
  localparam int BIDIR_SEL_BIT = 1;
  localparam int READBACK_EN_BIT = 2;
  localparam logic [DATA_W-1:0] REG_RESET = 20'h00000;
  // Link timing
  localparam int SYS_PERIOD_NS = 4;
  localparam int SCLK_PERIOD_NS = 32;
  localparam int SCLK_HALF_CYC = (SCLK_PERIOD_NS + 2 * SYS_PERIOD_NS - 1) / (2 * SYS_PERIOD_NS);
  // Host register map (APB byte offsets)
  localparam logic [7:0] HOST_CMD_OFS = 8'h00;
  localparam logic [7:0] HOST_STATUS_OFS = 8'h04;
  localparam logic [7:0] HOST_RDATA_OFS = 8'h08;
  localparam int CMD_3W_BIT = 31;
  localparam int CMD_READ_BIT = 30;
  // Host sequencer states
  typedef enum logic [2:0] {H_IDLE, H_LOW, H_HIGH, H_TAIL, H_GAP} ascp_host_state_t;
endpackage

// file: src/ascp_link_if.sv
`timescale 1ns/100ps
// ==========================================================================
// Link between host and device; resolves the shared serial input line
interface ascp_link_if;
  // Serial clock and frame strobe, both made by the host
  logic sclk;
  logic frame_strobe_n;
  // Serial input line, driven by either end
  logic sil_host_out;
  logic sil_host_oe;
  logic sil_dev_out;
  logic sil_dev_oe;
  logic serial_input_line;
  // Readback pin shared with the general-purpose function
  logic readback_output;
  // Wire level: the driving end wins, the internal pull-down otherwise
  assign serial_input_line = sil_host_oe ? sil_host_out : (sil_dev_oe ? sil_dev_out : 1'b0);
  modport dev (
    input sclk, frame_strobe_n, serial_input_line,
    output sil_dev_out, sil_dev_oe, readback_output
  );
  modport host (
    output sclk, frame_strobe_n, sil_host_out, sil_host_oe,
    input serial_input_line, readback_output
  );
endinterface

// file: src/ascp_device.sv
`timescale 1ns/100ps
// Behaviour
// - Clock, strobe, input line; separate readback line
// - Frame is 10 address then 20 data bits
// - Shift input on clock rise while strobe low
// - Strobe rise latches all 30 shifted bits
// - Address 0 bit 0 selects read mode
// - Host sends address most significant bit first
// - Write frame stores data at its address
// - Short final frame is discarded entirely
// - Readback pin shared, enabled by register bit
// - Four-wire read uses separate readback line
// - Bidir bit turns input line two-way
// - Turnaround on clock fall after address
// - Input line has internal pull-down
module ascp_device
  import ascp_pkg::*;
#(
  parameter int NUM_REGS = 4
) (
  // Clock and reset
  input wire logic sys_clk_in,
  input wire logic rst_in,
  // Link to the host
  ascp_link_if.dev link,
  // General-purpose level for the shared pin
  input wire logic gpio_level_in,
  // Register contents and frame events
  output logic [NUM_REGS*DATA_W-1:0] reg_file_out,
  output logic frame_done_out,
  output logic frame_drop_out
);

  // ========================================================================
  // Declarations
  localparam int IDX_W = (NUM_REGS > 1) ? $clog2(NUM_REGS) : 1;

  // Synchronisers for the link inputs
  logic sclk_s1;
  logic sclk_s2;
  logic sclk_d;
  logic strb_s1;
  logic strb_s2;
  logic strb_d;
  logic sil_s1;
  logic sil_s2;
  // Frame state
  logic [FRAME_W-1:0] shift_in;
  logic [CNT_W-1:0] bit_cnt;
  logic rd_active;
  logic [DATA_W-1:0] shift_out;
  logic dev_drive;
  logic rb_pin;
  // Register file
  logic [DATA_W-1:0] regs [NUM_REGS];

  // ========================================================================
  // Decoding
  // Edges seen by the system clock
  wire sclk_rise = sclk_s2 & ~sclk_d;
  wire sclk_fall = ~sclk_s2 & sclk_d;
  wire strb_low = ~strb_s2;
  wire strb_rise = strb_s2 & ~strb_d;
  // Mode bits of the control register
  wire rw_sel = regs[0][RW_SEL_BIT];
  wire bidir_sel = regs[0][BIDIR_SEL_BIT];
  wire rb_en = regs[0][READBACK_EN_BIT];
  // Address as seen after ten bits, MSB arrived first
  wire [ADDR_W-1:0] early_addr = shift_in[ADDR_W-1:0];
  // Read frame: read mode and not the control register
  wire rd_req = rw_sel & (early_addr != CTRL_ADDR);
  wire early_hit = early_addr < ADDR_W'(NUM_REGS);
  wire [IDX_W-1:0] early_idx = early_addr[IDX_W-1:0];
  // Full frame fields at the strobe rise
  wire [ADDR_W-1:0] frame_addr = shift_in[FRAME_W-1:DATA_W];
  wire [DATA_W-1:0] frame_data = shift_in[DATA_W-1:0];
  wire frame_hit = frame_addr < ADDR_W'(NUM_REGS);
  wire [IDX_W-1:0] frame_idx = frame_addr[IDX_W-1:0];
  // Commit only a complete write frame
  wire frame_full = bit_cnt == FRAME_CNT;
  wire do_write = strb_rise & frame_full & ~rd_active & frame_hit;
  // Start of the readback data phase
  wire rd_start = sclk_fall & strb_low & (bit_cnt == ADDR_CNT) & ~rd_active & rd_req;
  // Shared pin level: readback when enabled, else the general function
  wire next_rb_pin = rb_en ? (rd_active & shift_out[DATA_W-1]) : gpio_level_in;

  // ========================================================================
  // Input synchronisers, two flops before any use
  always_ff @(posedge sys_clk_in or posedge rst_in) begin
    if (rst_in) begin
      sclk_s1 <= 1'b0;
      sclk_s2 <= 1'b0;
      sclk_d <= 1'b0;
      strb_s1 <= 1'b1;
      strb_s2 <= 1'b1;
      strb_d <= 1'b1;
      sil_s1 <= 1'b0;
      sil_s2 <= 1'b0;
    end else begin
      sclk_s1 <= link.sclk;
      sclk_s2 <= sclk_s1;
      sclk_d <= sclk_s2;
      strb_s1 <= link.frame_strobe_n;
      strb_s2 <= strb_s1;
      strb_d <= strb_s2;
      sil_s1 <= link.serial_input_line;
      sil_s2 <= sil_s1;
    end
  end

  // ========================================================================
  // Input shift register and bit counter
  always_ff @(posedge sys_clk_in or posedge rst_in) begin
    if (rst_in) begin
      shift_in <= '0;
      bit_cnt <= '0;
    end else if (~strb_low) begin
      // Strobe high: the next frame starts from zero
      bit_cnt <= '0;
    end else if (sclk_rise) begin
      shift_in <= {shift_in[FRAME_W-2:0], sil_s2};
      // Counter saturates so overlong frames never match
      if (bit_cnt != CNT_MAX) begin
        bit_cnt <= bit_cnt + 5'h01;
      end
    end
  end

  // ========================================================================
  // Readback sequencer
  always_ff @(posedge sys_clk_in or posedge rst_in) begin
    if (rst_in) begin
      rd_active <= 1'b0;
      shift_out <= '0;
      dev_drive <= 1'b0;
    end else if (~strb_low) begin
      // Frame over: release the line
      rd_active <= 1'b0;
      dev_drive <= 1'b0;
    end else if (rd_start) begin
      // Load the addressed register on the fall after the address
      rd_active <= 1'b1;
      shift_out <= early_hit ? regs[early_idx] : '0;
      dev_drive <= bidir_sel;
    end else if (sclk_fall & rd_active) begin
      // Next data bit, MSB first
      shift_out <= {shift_out[DATA_W-2:0], 1'b0};
    end
  end

  // ========================================================================
  // Register file, written only by complete frames
  always_ff @(posedge sys_clk_in or posedge rst_in) begin
    if (rst_in) begin
      for (int i = 0; i < NUM_REGS; i++) begin
        regs[i] <= REG_RESET;
      end
    end else if (do_write) begin
      regs[frame_idx] <= frame_data;
    end
  end

  // ========================================================================
  // Shared pin and frame events
  always_ff @(posedge sys_clk_in or posedge rst_in) begin
    if (rst_in) begin
      rb_pin <= 1'b0;
      frame_done_out <= 1'b0;
      frame_drop_out <= 1'b0;
    end else begin
      rb_pin <= next_rb_pin;
      frame_done_out <= strb_rise & frame_full;
      // Partial or overlong frame: nothing is updated
      frame_drop_out <= strb_rise & ~frame_full & (bit_cnt != 5'h00);
    end
  end

  // ========================================================================
  // Outputs
  // Undriven line reads low through the pull-down in the pad
  assign link.sil_dev_oe = dev_drive;
  assign link.sil_dev_out = shift_out[DATA_W-1];
  assign link.readback_output = rb_pin;
  // Flattened register contents, register 0 in the low bits
  for (genvar g = 0; g < NUM_REGS; g++) begin : g_out
    assign reg_file_out[g*DATA_W +: DATA_W] = regs[g];
  end

endmodule

// file: src/ascp_host.sv
`timescale 1ns/100ps
// ==========================================================================
// Serial host: APB command registers, makes clock and strobe
module ascp_host
  import ascp_pkg::*;
#(
  parameter int HALF_CYC = SCLK_HALF_CYC
) (
  // Clock and reset
  input wire logic sys_clk_in,
  input wire logic rst_in,
  // APB slave
  input wire logic psel_in,
  input wire logic penable_in,
  input wire logic pwrite_in,
  input wire logic [7:0] paddr_in,
  input wire logic [31:0] pwdata_in,
  output logic [31:0] prdata_out,
  output logic pready_out,
  output logic pslverr_out,
  // Link to the device
  ascp_link_if.host link
);

  // ========================================================================
  // Declarations
  ascp_host_state_t state;
  logic [7:0] cnt;
  logic [CNT_W-1:0] bit_idx;
  logic [FRAME_W-1:0] tx_sh;
  logic [DATA_W-1:0] rx_sh;
  logic [DATA_W-1:0] rdata;
  logic cmd_read;
  logic cmd_3w;
  logic sclk;
  logic strb_n;
  logic sil_o;
  logic sil_oe;
  // Synchronisers for the returning lines
  logic sil_s1;
  logic sil_s2;
  logic rb_s1;
  logic rb_s2;

  // ========================================================================
  // Decoding
  wire access = psel_in & penable_in;
  wire setup = psel_in & ~penable_in;
  wire busy = state != H_IDLE;
  wire map_hit = (paddr_in == HOST_CMD_OFS) | (paddr_in == HOST_STATUS_OFS)
               | (paddr_in == HOST_RDATA_OFS);
  // Command write while busy is dropped
  wire start = access & pwrite_in & (paddr_in == HOST_CMD_OFS) & ~busy;
  wire half_done = cnt == 8'(HALF_CYC - 1);
  wire rx_bit = cmd_3w ? sil_s2 : rb_s2;
  wire last_bit = bit_idx == FRAME_CNT - 5'h01;
  // Turnaround: release the line on the fall after the last address bit
  wire release_now = cmd_read & cmd_3w & (bit_idx == ADDR_CNT - 5'h01);
  wire [31:0] next_rdata = (paddr_in == HOST_STATUS_OFS) ? {31'h00000000, busy}
                         : (paddr_in == HOST_RDATA_OFS) ? {12'h000, rdata} : 32'h00000000;

  // ========================================================================
  // APB read data, fetched in the setup cycle
  always_ff @(posedge sys_clk_in or posedge rst_in) begin
    if (rst_in) begin
      prdata_out <= '0;
    end else if (setup) begin
      prdata_out <= next_rdata;
    end
  end

  // ========================================================================
  // Synchronisers
  always_ff @(posedge sys_clk_in or posedge rst_in) begin
    if (rst_in) begin
      sil_s1 <= 1'b0;
      sil_s2 <= 1'b0;
      rb_s1 <= 1'b0;
      rb_s2 <= 1'b0;
    end else begin
      sil_s1 <= link.serial_input_line;
      sil_s2 <= sil_s1;
      rb_s1 <= link.readback_output;
      rb_s2 <= rb_s1;
    end
  end

  // ========================================================================
  // Frame sequencer
  always_ff @(posedge sys_clk_in or posedge rst_in) begin
    if (rst_in) begin
      state <= H_IDLE;
      cnt <= '0;
      bit_idx <= '0;
      tx_sh <= '0;
      rx_sh <= '0;
      rdata <= '0;
      cmd_read <= 1'b0;
      cmd_3w <= 1'b0;
      sclk <= 1'b0;
      strb_n <= 1'b1;
      sil_o <= 1'b0;
      sil_oe <= 1'b0;
    end else begin
      cnt <= (busy & ~half_done) ? cnt + 8'h01 : 8'h00;
      case (state)
        H_IDLE: begin
          if (start) begin
            // Drop the strobe and present the address MSB
            tx_sh <= pwdata_in[FRAME_W-1:0];
            cmd_read <= pwdata_in[CMD_READ_BIT];
            cmd_3w <= pwdata_in[CMD_3W_BIT];
            bit_idx <= '0;
            strb_n <= 1'b0;
            sil_o <= pwdata_in[FRAME_W-1];
            sil_oe <= 1'b1;
            state <= H_LOW;
          end
        end
        H_LOW: begin
          // Data stable for a half period before the rise
          if (half_done) begin
            sclk <= 1'b1;
            state <= H_HIGH;
          end
        end
        H_HIGH: begin
          if (half_done) begin
            sclk <= 1'b0;
            // Readback bits sampled at the end of the high phase
            if (cmd_read & (bit_idx >= ADDR_CNT)) begin
              rx_sh <= {rx_sh[DATA_W-2:0], rx_bit};
            end
            if (last_bit) begin
              state <= H_TAIL;
            end else begin
              bit_idx <= bit_idx + 5'h01;
              tx_sh <= {tx_sh[FRAME_W-2:0], 1'b0};
              sil_o <= tx_sh[FRAME_W-2];
              if (release_now) begin
                sil_oe <= 1'b0;
              end
              state <= H_LOW;
            end
          end
        end
        H_TAIL: begin
          // Strobe rises after a half period with the clock low
          if (half_done) begin
            strb_n <= 1'b1;
            sil_oe <= 1'b0;
            if (cmd_read) begin
              rdata <= rx_sh;
            end
            state <= H_GAP;
          end
        end
        H_GAP: begin
          if (half_done) begin
            state <= H_IDLE;
          end
        end
        default: begin
          state <= H_IDLE;
        end
      endcase
    end
  end

  // ========================================================================
  // Outputs
  assign pready_out = 1'b1;
  assign pslverr_out = access & ~map_hit;
  assign link.sclk = sclk;
  assign link.frame_strobe_n = strb_n;
  assign link.sil_host_out = sil_o;
  assign link.sil_host_oe = sil_oe;

endmodule

// file: testbench/ascp_link_chk.sv
`timescale 1ns/100ps
// ============================================================
// Link protocol checker, sits beside the host-device link
module ascp_link_chk (
  // Clock and reset
  input wire logic sys_clk_in,
  input wire logic rst_in,
  // Link signals
  input wire logic sclk,
  input wire logic frame_strobe_n,
  input wire logic sil_host_out,
  input wire logic sil_host_oe,
  input wire logic sil_dev_out,
  input wire logic sil_dev_oe,
  input wire logic serial_input_line
);
  default clocking cb @(posedge sys_clk_in);
  endclocking
  default disable iff (rst_in);
  // Previous clock level and clock rises seen in this frame
  logic sclk_q;
  logic [4:0] rise_cnt;
  // Count serial clock rises while the strobe is low
  always_ff @(posedge sys_clk_in or posedge rst_in) begin
    if (rst_in) begin
      sclk_q <= 1'b0;
      rise_cnt <= 5'h00;
    end else begin
      sclk_q <= sclk;
      if (frame_strobe_n) begin
        rise_cnt <= 5'h00;
      end else if (sclk && !sclk_q) begin
        rise_cnt <= rise_cnt + 5'h01;
      end
    end
  end
  property p_idle_low; frame_strobe_n |-> !sclk; endproperty
  a_idle_low: assert property (p_idle_low) else $error("clock runs outside frame");
  property p_half; $rose(sclk) |-> sclk [*4] ##1 !sclk; endproperty
  a_half: assert property (p_half) else $error("clock high phase length wrong");
  property p_count; $rose(frame_strobe_n) |-> rise_cnt == 5'h1E; endproperty
  a_count: assert property (p_count) else $error("frame not thirty bits");
  property p_stable; $rose(sclk) && sil_host_oe |-> $stable(sil_host_out); endproperty
  a_stable: assert property (p_stable) else $error("host data moved at clock rise");
  property p_turn; $rose(sil_dev_oe) |-> rise_cnt == 5'h0A && !sil_host_oe && !sclk; endproperty
  a_turn: assert property (p_turn) else $error("turnaround at wrong point");
  property p_release; $rose(frame_strobe_n) |-> ##[1:8] !sil_dev_oe; endproperty
  a_release: assert property (p_release) else $error("device kept line after frame");
  property p_clash; !(sil_host_oe && sil_dev_oe); endproperty
  a_clash: assert property (p_clash) else $error("both ends drive the line");
  property p_dev_hold; sil_dev_oe && sclk |-> $stable(sil_dev_out); endproperty
  a_dev_hold: assert property (p_dev_hold) else $error("read bit moved in high phase");
  property p_pull; !sil_host_oe && !sil_dev_oe |-> !serial_input_line; endproperty
  a_pull: assert property (p_pull) else $error("released line not pulled low");
endmodule

// file: testbench/test_afe_serial_config_port.sv
`timescale 1ns/100ps
// ============================================================
// Bench: host and device joined, plus a bench-driven second link
module test_afe_serial_config_port;
  import ascp_pkg::*;
  // Clock, reset, APB and pin stimulus
  logic sys_clk_in = 1'b0;
  logic rst_in = 1'b1;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h0;
  logic gpio_level = 1'b1;
  // Design outputs
  logic [31:0] prdata;
  logic pready;
  logic pslverr;
  logic [79:0] regs;
  logic [79:0] regs2;
  logic done;
  logic drop;
  logic done2;
  logic drop2;
  // Bench state
  logic [31:0] rd_data;
  logic rd_err;
  logic [19:0] exp_regs [4];
  logic [19:0] d;
  logic [9:0] a;
  int fails = 0;
  int checks_done = 0;
  int cycles = 0;
  int dones2 = 0;
  int drops2 = 0;
  int drops = 0;
  int seed;
  ascp_link_if link();
  ascp_link_if link2();
  always #2 sys_clk_in = ~sys_clk_in;
  ascp_host ascp_host_inst (.sys_clk_in(sys_clk_in), .rst_in(rst_in), .psel_in(psel),
    .penable_in(penable), .pwrite_in(pwrite), .paddr_in(paddr), .pwdata_in(pwdata),
    .prdata_out(prdata), .pready_out(pready), .pslverr_out(pslverr), .link(link));
  ascp_device ascp_device_inst (.sys_clk_in(sys_clk_in), .rst_in(rst_in), .link(link),
    .gpio_level_in(gpio_level), .reg_file_out(regs), .frame_done_out(done),
    .frame_drop_out(drop));
  ascp_device ascp_device_inst_b (.sys_clk_in(sys_clk_in), .rst_in(rst_in), .link(link2),
    .gpio_level_in(gpio_level), .reg_file_out(regs2), .frame_done_out(done2),
    .frame_drop_out(drop2));
  ascp_link_chk ascp_link_chk_inst (.sys_clk_in(sys_clk_in), .rst_in(rst_in),
    .sclk(link.sclk), .frame_strobe_n(link.frame_strobe_n), .sil_host_out(link.sil_host_out),
    .sil_host_oe(link.sil_host_oe), .sil_dev_out(link.sil_dev_out),
    .sil_dev_oe(link.sil_dev_oe), .serial_input_line(link.serial_input_line));
  // Closing report and verdict
  task finish_test;
    $display("checks %0d fails %0d", checks_done, fails);
    if (fails == 0 && checks_done > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask
  // Hang guard, frame event counters of the second device and drop counter of the first
  always @(posedge sys_clk_in) begin
    cycles++;
    if (done2 === 1'b1) dones2++;
    if (drop2 === 1'b1) drops2++;
    if (drop === 1'b1) drops++;
    if (cycles == 40000) begin
      fails++;
      finish_test;
    end
  end
  // Compare and report
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    checks_done++;
    if (seen !== exp) begin
      fails++;
      $display("BAD %0t seen %h expected %h", $time, seen, exp);
    end
  endtask
  // One APB transfer; read data and error taken at the ready edge
  task automatic apb(input logic w, input logic [7:0] ad, input logic [31:0] wd);
    @(posedge sys_clk_in);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= ad;
    pwdata <= wd;
    @(posedge sys_clk_in);
    penable <= 1'b1;
    do @(posedge sys_clk_in); while (pready !== 1'b1);
    rd_data = prdata;
    rd_err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  // Command word: wiring, direction, address, data
  function automatic logic [31:0] cmd(input logic rd, input logic tw, input logic [9:0] ad,
      input logic [19:0] dt);
    return {tw, rd, ad, dt};
  endfunction
  // Issue a frame and wait until it ends and the host is idle
  task automatic run_cmd(input logic [31:0] w);
    int n;
    n = 0;
    apb(1'b1, HOST_CMD_OFS, w);
    do begin
      @(posedge sys_clk_in);
      n++;
    end while (done !== 1'b1 && n < 2000);
    check({31'h0, done}, 32'h1);
    do apb(1'b0, HOST_STATUS_OFS, 32'h0); while (rd_data[0] !== 1'b0);
  endtask
  // Hand-made frame of n bits, MSB first, on the second link
  task automatic raw(input int n, input logic [31:0] w);
    @(posedge sys_clk_in);
    link2.frame_strobe_n <= 1'b0;
    link2.sil_host_oe <= 1'b1;
    for (int i = n - 1; i >= 0; i--) begin
      link2.sil_host_out <= w[i];
      repeat (4) @(posedge sys_clk_in);
      link2.sclk <= 1'b1;
      repeat (4) @(posedge sys_clk_in);
      link2.sclk <= 1'b0;
    end
    repeat (4) @(posedge sys_clk_in);
    link2.frame_strobe_n <= 1'b1;
    link2.sil_host_oe <= 1'b0;
    repeat (12) @(posedge sys_clk_in);
  endtask
  // Main sequence
  initial begin
    seed = 32'h1a3891a6;
    // Bench owns the host side of the second link
    link2.sclk = 1'b0;
    link2.frame_strobe_n = 1'b1;
    link2.sil_host_oe = 1'b0;
    link2.sil_host_out = 1'b0;
    for (int g = 0; g < 4; g++) exp_regs[g] = 20'h00000;
    repeat (8) @(posedge sys_clk_in);
    rst_in <= 1'b0;
    // Reset values, unmapped host offset, shared pin as general purpose
    for (int g = 0; g < 4; g++) check({12'h0, regs[g*20 +: 20]}, 32'h0);
    apb(1'b0, 8'h0C, 32'h0);
    check({31'h0, rd_err}, 32'h1);
    check({31'h0, link.readback_output}, 32'h1);
    // Shared pin follows the general-purpose level while readback is off
    gpio_level <= 1'b0;
    repeat (3) @(posedge sys_clk_in);
    check({31'h0, link.readback_output}, 32'h0);
    gpio_level <= 1'b1;
    // Random writes with extreme data, other registers untouched
    for (int k = 0; k < 6; k++) begin
      a = 10'(1 + {$random(seed)} % 3);
      d = (k == 0) ? 20'hFFFFF : ((k == 1) ? 20'h00000 : 20'($random(seed)));
      run_cmd(cmd(1'b0, 1'b0, a, d));
      exp_regs[a] = d;
      for (int g = 1; g < 4; g++) check({12'h0, regs[g*20 +: 20]}, {12'h0, exp_regs[g]});
    end
    // Command written while a frame runs is ignored
    apb(1'b1, HOST_CMD_OFS, cmd(1'b0, 1'b0, 10'h002, 20'h0F0F0));
    run_cmd(cmd(1'b0, 1'b0, 10'h002, 20'h12345));
    exp_regs[2] = 20'h0F0F0;
    check({12'h0, regs[59:40]}, {12'h0, exp_regs[2]});
    // Four-wire reads on the shared pin
    run_cmd(cmd(1'b0, 1'b0, CTRL_ADDR, 20'h00005));
    check({12'h0, regs[19:0]}, 32'h5);
    check({31'h0, link.readback_output}, 32'h0);
    for (int g = 1; g < 4; g++) begin
      run_cmd(cmd(1'b1, 1'b0, 10'(g), 20'($random(seed))));
      apb(1'b0, HOST_RDATA_OFS, 32'h0);
      check({12'h0, rd_data[19:0]}, {12'h0, exp_regs[g]});
      check({31'h0, rd_err}, 32'h0);
      check({12'h0, regs[g*20 +: 20]}, {12'h0, exp_regs[g]});
    end
    // Three-wire reads over the turned-round input line
    run_cmd(cmd(1'b0, 1'b0, CTRL_ADDR, 20'h00003));
    for (int g = 1; g < 4; g++) begin
      run_cmd(cmd(1'b1, 1'b1, 10'(g), 20'h00000));
      apb(1'b0, HOST_RDATA_OFS, 32'h0);
      check({12'h0, rd_data[19:0]}, {12'h0, exp_regs[g]});
    end
    // Back to write mode
    run_cmd(cmd(1'b0, 1'b0, CTRL_ADDR, 20'h00000));
    check({12'h0, regs[19:0]}, 32'h0);
    // Whole, short and long frames on the second link
    d = 20'($random(seed));
    raw(30, {2'b00, 10'h001, d});
    check({12'h0, regs2[39:20]}, {12'h0, d});
    raw(29, $random(seed));
    raw(31, $random(seed));
    check({12'h0, regs2[39:20]}, {12'h0, d});
    check(32'(dones2), 32'h1);
    check(32'(drops2), 32'h2);
    check(32'(drops), 32'h0);
    finish_test;
  end
endmodule
